// [bench/cems_core_status_properties.sv]
// Checker for the exception mask and status block
`timescale 1ns/100ps
`include "cems_map.svh"
module cems_core_status_props
  import cems_pkg::*;
#(
  parameter int PRIO_BITS = 4
) (
  // Clock, reset and software access
  input wire logic           core_clk,
  input wire logic           rst_n,
  input wire cems_sreg_req_s sreg_req,
  input wire logic [31:0]    sreg_rdata,
  // Core events and status
  input wire cems_core_ev_s  core_ev,
  input wire logic           exec_attempt,
  input wire logic           handler_mode,
  input wire logic           use_process_stack,
  input wire logic           float_preserve,
  input wire logic           state_fault,
  input wire logic [31:0]    exec_status
);
  localparam logic [7:0] TH_MASK = 8'hff << (8 - PRIO_BITS);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Events that may legally move mode and state in the same cycle
  wire logic quiet = !core_ev.entry && !core_ev.ret;
  wire logic rd_th = sreg_req.rd && sreg_req.sel == `CEMS_SEL_THRESH;
  wire logic wr_th = sreg_req.wr && sreg_req.sel == `CEMS_SEL_THRESH;
  logic [7:0] thw_q;
  // Written threshold as the register should keep it
  always_ff @(posedge core_clk) begin
    thw_q <= sreg_req.wdata[7:0] & TH_MASK;
  end
  property p_xrd; sreg_req.rd && sreg_req.sel == `CEMS_SEL_EXEC |=> sreg_rdata == 32'h0; endproperty
  a_xrd: assert property (p_xrd) else $error("status read not zero");
  property p_idle; !sreg_req.rd |=> sreg_rdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data without read");
  property p_exc; sreg_req.rd && sreg_req.sel == `CEMS_SEL_CURRENT_EXCEPTION_NUMBER_NUM && quiet
    |=> sreg_rdata[31:9] == 23'h0 && (sreg_rdata[8:0] != 9'h0) == handler_mode; endproperty
  a_exc: assert property (p_exc) else $error("exception number view wrong");
  property p_thr; wr_th ##1 rd_th |=> sreg_rdata == {24'h0, $past(thw_q)}; endproperty
  a_thr: assert property (p_thr) else $error("threshold low bits kept");
  property p_sf; state_fault |-> exec_attempt && !exec_status[24]; endproperty
  a_sf: assert property (p_sf) else $error("state fault without cause");
  property p_msp; handler_mode |-> !use_process_stack; endproperty
  a_msp: assert property (p_msp) else $error("handler on process stack");
  property p_iw; core_ev.interwork && quiet |=> exec_status[24] == $past(core_ev.interwork_b0);
  endproperty
  a_iw: assert property (p_iw) else $error("state bit not from branch");
  property p_fp; core_ev.float_use && quiet |=> float_preserve; endproperty
  a_fp: assert property (p_fp) else $error("float context not set");
  property p_ici; core_ev.multi_int && quiet |=> exec_status[15:12] == $past(core_ev.multi_next)
    && exec_status[26:25] == 2'h0 && exec_status[11:10] == 2'h0; endproperty
  a_ici: assert property (p_ici) else $error("progress field wrong");
  c_ici: cover property (core_ev.multi_int);
  c_sf: cover property (state_fault);
  c_thr: cover property (wr_th ##1 rd_th);
endmodule
bind cems_core_status cems_core_status_props #(.PRIO_BITS(PRIO_BITS)) u_chk (
  .core_clk(core_clk), .rst_n(rst_n), .sreg_req(sreg_req), .sreg_rdata(sreg_rdata),
  .core_ev(core_ev), .exec_attempt(exec_attempt), .handler_mode(handler_mode),
  .use_process_stack(use_process_stack), .float_preserve(float_preserve),
  .state_fault(state_fault), .exec_status(exec_status));

// [bench/cems_core_status_tb_top.sv]
// Self-checking bench for the exception mask and status block
`timescale 1ns/100ps
`include "cems_map.svh"
module cems_core_status_tb_top
  import cems_pkg::*;
;
  logic           core_clk = 0, rst_n = 0, exec_attempt = 0;
  cems_sreg_req_s req = '0;
  cems_core_ev_s  ev = '0, e = '0;
  logic [7:0]     pend_prio = 8'h00;
  logic [8:0]     pend_num = 9'h000;
  logic [31:0]    rdata, xs;
  logic           hm, ups, fp, pa, sf, mr;
  logic [3:0]     rr;
  int             fail_count = 0, n_tests = 0, seed = 73, m_th = 0, a;
  always #2 core_clk = ~core_clk;
  cems_core_status #(.PRIO_BITS(4)) dut_u (
    .core_clk(core_clk), .rst_n(rst_n), .sreg_req(req), .sreg_rdata(rdata),
    .core_ev(ev), .exec_attempt(exec_attempt), .reset_vec_b0(1'b1),
    .pend_prio(pend_prio), .pend_num(pend_num), .handler_mode(hm),
    .use_process_stack(ups), .float_preserve(fp), .pend_allowed(pa),
    .state_fault(sf), .multi_resume(mr), .resume_reg(rr), .exec_status(xs));
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict;
    if (fail_count == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic tick;
    @(posedge core_clk);
    #1;
  endtask
  task automatic wr(logic [2:0] s, logic [31:0] d);
    req = '{rd: 1'b0, wr: 1'b1, sel: s, wdata: d};
    tick;
    req = '0;
    tick;
  endtask
  task automatic rd(logic [2:0] s, logic [31:0] x, string nm);
    req = '{rd: 1'b1, wr: 1'b0, sel: s, wdata: 32'h0};
    tick;
    chk(nm, rdata, x);
    req = '0;
    tick;
  endtask
  // One event pulse; a return restores the status as it stands
  task automatic go;
    ev = e;
    ev.ret_psr = xs;
    tick;
    ev = '0;
    e = '0;
    tick;
  endtask
  // Every software view but execution status, and each mode output, against the model
  task automatic all(int ex, int cm, int fm, int ss, int fl);
    rd(`CEMS_SEL_CURRENT_EXCEPTION_NUMBER_NUM, ex, "exc");
    rd(`CEMS_SEL_CFG_MASK, cm, "cfg");
    rd(`CEMS_SEL_FAULT_MASK, fm, "flt");
    rd(`CEMS_SEL_THRESH, m_th, "thr");
    rd(`CEMS_SEL_CTRL, fl * 4 + ss * 2, "ctl");
    chk("hnd", hm, ex != 0);
    chk("psp", ups, ss != 0 && ex == 0);
    chk("fpc", fp, fl);
  endtask
  initial begin
    repeat (20) tick;
    rst_n = 1;
    repeat (2) tick;
    all(0, 0, 0, 0, 0);
    chk("xs", xs, 32'h0100_0000);
    rd(`CEMS_SEL_EXEC, 0, "xrd");
    wr(`CEMS_SEL_EXEC, 32'hffff_ffff);
    wr(`CEMS_SEL_CURRENT_EXCEPTION_NUMBER_NUM, 32'h1ff);
    chk("xwr", xs, 32'h0100_0000);
    rd(3'h6, 0, "rsv");
    wr(`CEMS_SEL_THRESH, 32'h35);
    m_th = 'h30;
    // barrier slot: a spare cycle follows the select write
    wr(`CEMS_SEL_CTRL, 32'h6);
    all(0, 0, 0, 1, 1);
    // Random masks and candidates; small numbers hit the fixed ones
    for (int i = 0; i < 64; i++) begin
      a = $random(seed);
      wr(`CEMS_SEL_CFG_MASK, a[0]);
      wr(`CEMS_SEL_FAULT_MASK, a[1]);
      wr(`CEMS_SEL_THRESH, a[15:8]);
      m_th = a[15:8] & 'hf0;
      pend_prio = a[23:16];
      pend_num = a[31] ? {5'h0, a[27:24]} : {1'b0, a[31:24]};
      tick;
      chk("pa", pa, !(a[1] && pend_num != 2) && !(a[0] && pend_num >= 4)
          && !(m_th != 0 && pend_num >= 4 && pend_prio >= m_th));
    end
    wr(`CEMS_SEL_CFG_MASK, 0);
    wr(`CEMS_SEL_THRESH, 0);
    m_th = 0;
    // Nonmaskable handler keeps the fault mask when it exits
    e.entry = 1;
    e.entry_num = `CEMS_EXC_NMI;
    e.entry_vec_b0 = 1;
    go;
    wr(`CEMS_SEL_FAULT_MASK, 1);
    wr(`CEMS_SEL_CTRL, 32'h2);
    all(2, 0, 1, 0, 0);
    e.ret = 1;
    e.ret_code = 32'h10;
    e.ret_num = 9'h005;
    go;
    all(5, 0, 1, 0, 0);
    e.float_use = 1;
    go;
    chk("fpu", fp, 1);
    e.ret = 1;
    e.ret_code = 32'h1c;
    go;
    all(0, 0, 0, 1, 0);
    // Block state, then an interrupted multiple and its resume
    e.cb_open = 1;
    e.cb_state = 8'hc5;
    go;
    chk("cb", xs, 32'h0700_1400);
    e.multi_int = 1;
    e.multi_next = 4'h9;
    go;
    chk("ici", xs, 32'h0100_9000);
    e.entry = 1;
    e.entry_num = 9'h010;
    e.entry_vec_b0 = 1;
    go;
    e.ret = 1;
    e.ret_code = 32'h18;
    go;
    chk("res", {mr, rr}, 5'h19);
    e.multi_done = 1;
    go;
    chk("done", xs, 32'h0100_0000);
    chk("mr", mr, 0);
    // A cleared state bit makes execution fault
    exec_attempt = 1;
    e.interwork = 1;
    go;
    chk("sf", {sf, xs[24]}, 2'b10);
    e.interwork = 1;
    e.interwork_b0 = 1;
    go;
    chk("sf1", {sf, xs[24]}, 2'b01);
    give_verdict;
  end
  // Watchdog well beyond the length of the sequence
  initial begin
    repeat (5000) @(posedge core_clk);
    fail_count++;
    give_verdict;
  end
endmodule

// [logic/cems_core_status.sv]
// Exception number, execution state, mask and thread control registers
`timescale 1ns/100ps
`include "cems_map.svh"
module cems_core_status
  import cems_pkg::*;
#(
  parameter int PRIO_BITS = 4
) (
  // Clock and reset
  input  wire logic           core_clk,
  input  wire logic           rst_n,
  // Special register access
  input  wire cems_sreg_req_s sreg_req,
  output logic [31:0]         sreg_rdata,
  // Core events
  input  wire cems_core_ev_s  core_ev,
  input  wire logic           exec_attempt,
  input  wire logic           reset_vec_b0,
  input  wire logic [7:0]     pend_prio,
  input  wire logic [8:0]     pend_num,
  // Status to the core
  output logic                handler_mode,
  output logic                use_process_stack,
  output logic                float_preserve,
  output logic                pend_allowed,
  output logic                state_fault,
  output logic                multi_resume,
  output logic [3:0]          resume_reg,
  output logic [31:0]         exec_status
);
  initial begin
    if (PRIO_BITS < 1 || PRIO_BITS > 8) begin
      $error("PRIO_BITS must be 1..8");
    end
  end

  localparam logic [7:0] PRIO_MASK = 8'(8'hff << (8 - PRIO_BITS));

  cems_state_s s_q;
  cems_state_s s_d;
  logic        boot_q;

  // Next-state logic for all special state
  always_comb begin
    s_d = s_q;
    s_d.rdata = `CEMS_ZERO32;
    // [RULE_22] handler mode entry
    if (core_ev.entry) begin
      s_d.exc_num = core_ev.entry_num;
      // [RULE_10] vector bit zero
      s_d.state_bit = core_ev.entry_vec_b0;
      // [RULE_18] handler stack fixed
      s_d.stack_sel = 1'b0;
      // [RULE_19] entry updates control
      s_d.float_act = 1'b0;
      s_d.cb_state = 8'h00;
    end else if (core_ev.ret) begin
      // [RULE_14] clear fault mask
      if (s_q.exc_num != `CEMS_EXC_NMI) begin
        s_d.fault_mask = 1'b0;
      end
      s_d.exc_num = core_ev.ret_code[`CEMS_RET_THREAD] ? `CEMS_EXC_THREAD : core_ev.ret_num;
      // [RULE_20] return selects stack
      s_d.stack_sel = core_ev.ret_code[`CEMS_RET_THREAD] & core_ev.ret_code[`CEMS_RET_PSTACK];
      // [RULE_19] return updates control
      s_d.float_act = ~core_ev.ret_code[`CEMS_RET_NOFLOAT];
      // [RULE_10] restored stacked status
      s_d.state_bit = core_ev.ret_psr[`CEMS_STATE_BIT];
      s_d.cb_state = {core_ev.ret_psr[`CEMS_CB_HI_HI:`CEMS_CB_HI_LO],
                      core_ev.ret_psr[`CEMS_CB_LO_HI:`CEMS_CB_LO_LO]};
    end else if (core_ev.interwork) begin
      // [RULE_10] branch exchange or pop
      s_d.state_bit = core_ev.interwork_b0;
    end
    // Conditional block tracking, length limited to four
    if (core_ev.cb_open) begin
      // [RULE_09] block length check
      s_d.cb_state = (core_ev.cb_state[2:0] == 3'h0) ? 8'h00 : core_ev.cb_state;
    end else if (core_ev.cb_step && s_q.cb_state != 8'h00) begin
      s_d.cb_state = (s_q.cb_state[3:0] == 4'h8) ? 8'h00
                   : {s_q.cb_state[7:5], s_q.cb_state[4:0] << 1};
    end
    // Multiple transfer suspend and resume
    case (s_q.mst)
      CEMS_IDLE: begin
        if (core_ev.multi_int) begin
          // [RULE_06] save next operand
          s_d.prog = core_ev.multi_next;
          s_d.mst = CEMS_SUSPENDED;
          // [RULE_08] progress clears block
          s_d.cb_state = 8'h00;
        end
      end
      CEMS_SUSPENDED: begin
        if (core_ev.ret && core_ev.ret_code[`CEMS_RET_THREAD]) begin
          s_d.mst = CEMS_RESUMING;
        end
      end
      CEMS_RESUMING: begin
        if (core_ev.multi_done) begin
          s_d.mst = CEMS_IDLE;
          s_d.prog = 4'h0;
        end else if (core_ev.multi_int) begin
          s_d.prog = core_ev.multi_next;
          s_d.mst = CEMS_SUSPENDED;
        end
      end
      default: begin
        s_d.mst = CEMS_IDLE;
      end
    endcase
    // [RULE_08] progress excludes block
    if (s_d.mst != CEMS_IDLE) begin
      s_d.cb_state = 8'h00;
    end
    // Software writes
    if (sreg_req.wr) begin
      case (sreg_req.sel)
        `CEMS_SEL_CFG_MASK: begin
          s_d.cfg_mask = sreg_req.wdata[0];
        end
        `CEMS_SEL_FAULT_MASK: begin
          s_d.fault_mask = sreg_req.wdata[0];
        end
        `CEMS_SEL_THRESH: begin
          // [RULE_16] low bits unimplemented
          s_d.thresh = sreg_req.wdata[7:0] & PRIO_MASK;
        end
        `CEMS_SEL_CTRL: begin
          // [RULE_18] ignore select in handler
          if (s_q.exc_num == `CEMS_EXC_THREAD && !core_ev.entry) begin
            // [RULE_23] stack select bit
            s_d.stack_sel = sreg_req.wdata[`CEMS_CTRL_STACK];
          end
          s_d.float_act = sreg_req.wdata[`CEMS_CTRL_FLOAT];
        end
        // [RULE_05] execution status write ignored
        default: begin
          s_d.exc_num = s_d.exc_num;
        end
      endcase
    end
    // [RULE_17] float context set by use
    if (core_ev.float_use) begin
      s_d.float_act = 1'b1;
    end
    // Software reads, registered
    if (sreg_req.rd) begin
      case (sreg_req.sel)
        // [RULE_01] exception number field
        `CEMS_SEL_CURRENT_EXCEPTION_NUMBER_NUM:   s_d.rdata = {23'h0, s_q.exc_num};
        `CEMS_SEL_CFG_MASK:   s_d.rdata = {31'h0, s_q.cfg_mask};
        `CEMS_SEL_FAULT_MASK: s_d.rdata = {31'h0, s_q.fault_mask};
        `CEMS_SEL_THRESH:     s_d.rdata = {24'h0, s_q.thresh};
        `CEMS_SEL_CTRL:       s_d.rdata = {29'h0, s_q.float_act, s_q.stack_sel, 1'b0};
        // [RULE_04] execution status reads zero
        default:              s_d.rdata = `CEMS_ZERO32;
      endcase
    end
  end

  // Single register for all state; reset vector bit captured after release
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_q <= '{exc_num: `CEMS_EXC_THREAD, cb_state: 8'h00, state_bit: 1'b1, prog: 4'h0,
               mst: CEMS_IDLE, cfg_mask: 1'b0, fault_mask: 1'b0, thresh: 8'h00,
               stack_sel: 1'b0, float_act: 1'b0, rdata: `CEMS_ZERO32};
      boot_q <= 1'b1;
    end else begin
      s_q <= s_d;
      boot_q <= 1'b0;
      // [RULE_10] reset vector bit zero
      if (boot_q) begin
        s_q.state_bit <= reset_vec_b0;
      end
    end
  end

  // Execution status view for the stacking logic
  always_comb begin
    exec_status = `CEMS_ZERO32;
    // [RULE_03] state bit position
    exec_status[`CEMS_STATE_BIT] = s_q.state_bit;
    if (s_q.mst != CEMS_IDLE) begin
      exec_status[`CEMS_PROG_HI:`CEMS_PROG_LO] = s_q.prog;
    end else begin
      // [RULE_02] split block fields
      exec_status[`CEMS_CB_HI_HI:`CEMS_CB_HI_LO] = s_q.cb_state[7:6];
      exec_status[`CEMS_CB_LO_HI:`CEMS_CB_LO_LO] = s_q.cb_state[5:0];
    end
  end

  // Masking of a pending exception; NMI and escalated fault have fixed priority
  always_comb begin
    pend_allowed = 1'b1;
    // [RULE_13] fault mask
    if (s_q.fault_mask && pend_num != `CEMS_EXC_NMI) begin
      pend_allowed = 1'b0;
    end
    // [RULE_12] configurable mask
    if (s_q.cfg_mask && pend_num >= `CEMS_EXC_FIRST_CFG) begin
      pend_allowed = 1'b0;
    end
    // [RULE_15] threshold compare
    if (s_q.thresh != 8'h00 && pend_num >= `CEMS_EXC_FIRST_CFG
        && (pend_prio & PRIO_MASK) >= s_q.thresh) begin
      pend_allowed = 1'b0;
    end
  end

  // Read data, mode, stack, float, fault and resume outputs
  assign sreg_rdata        = s_q.rdata;
  assign handler_mode      = (s_q.exc_num != `CEMS_EXC_THREAD);
  // [RULE_20] thread stack choice
  assign use_process_stack = ~handler_mode & s_q.stack_sel;
  assign float_preserve    = s_q.float_act;
  // [RULE_11] state bit fault
  assign state_fault       = exec_attempt & ~s_q.state_bit;
  // [RULE_07] resume from saved operand
  assign multi_resume      = (s_q.mst == CEMS_RESUMING);
  assign resume_reg        = s_q.prog;
endmodule

// [logic/cems_map.svh]
// Constants for the exception mask and status block
// Functional notes
// [RULE_01] Exception number in status bits 8:0
// [RULE_02] Conditional state in bits 26:25, 15:10
// [RULE_03] Compact-instruction state bit at 24
// [RULE_04] Software read of execution status returns zero
// [RULE_05] Software write to execution status ignored
// [RULE_06] Interrupted multiple saves next operand bits 15:12
// [RULE_07] Resume multiple from saved operand field
// [RULE_08] Progress state keeps 26:25, 11:10 zero
// [RULE_09] Conditional block covers at most four instructions
// [RULE_10] State bit cleared only by listed events
// [RULE_11] Execution with state bit zero faults
// [RULE_12] Mask bit blocks configurable-priority exceptions
// [RULE_13] Fault mask blocks all but nonmaskable
// [RULE_14] Fault mask cleared on non-nonmaskable exit
// [RULE_15] Nonzero threshold blocks priority greater-or-equal
// [RULE_16] Threshold low bits read zero, ignore writes
// [RULE_17] Thread control bit 2 flags float context
// [RULE_18] Handler mode uses main stack, ignores select
// [RULE_19] Entry and return update thread control
// [RULE_20] Thread stack switches by write or return
// [RULE_21] Software follows stack change with barrier
// [RULE_22] Every handler except reset runs in Handler
// [RULE_23] Thread control bit 1 selects stack pointer
`ifndef CEMS_MAP_SVH
`define CEMS_MAP_SVH
// Special register selectors
`define CEMS_SEL_CURRENT_EXCEPTION_NUMBER_NUM   3'h0
`define CEMS_SEL_EXEC       3'h1
`define CEMS_SEL_CFG_MASK   3'h2
`define CEMS_SEL_FAULT_MASK 3'h3
`define CEMS_SEL_THRESH     3'h4
`define CEMS_SEL_CTRL       3'h5
// Field positions
`define CEMS_EXC_HI        8
`define CEMS_CB_HI_HI      26
`define CEMS_CB_HI_LO      25
`define CEMS_STATE_BIT     24
`define CEMS_CB_LO_HI      15
`define CEMS_CB_LO_LO      10
`define CEMS_PROG_HI       15
`define CEMS_PROG_LO       12
`define CEMS_CTRL_FLOAT    2
`define CEMS_CTRL_STACK    1
// Exception numbers
`define CEMS_EXC_THREAD    9'h000
`define CEMS_EXC_NMI       9'h002
`define CEMS_EXC_ESC_FAULT 9'h003
`define CEMS_EXC_FIRST_CFG 9'h004
`define CEMS_EXC_ILLEGAL   9'h006
// Return code bits: bit 3 back to thread, bit 2 process stack, bit 4 clear = float frame
`define CEMS_RET_THREAD    3
`define CEMS_RET_PSTACK    2
`define CEMS_RET_NOFLOAT   4
// Reset values and block length limit
`define CEMS_EXEC_RST      32'h0100_0000
`define CEMS_ZERO32        32'h0000_0000
`define CEMS_MAX_CB_LEN    3'h4
`endif

// [logic/cems_pkg.sv]
// Types for the exception mask and status block
package cems_pkg;
  // Software special register access
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [2:0]  sel;
    logic [31:0] wdata;
  } cems_sreg_req_s;
  // Core pipeline events
  typedef struct packed {
    logic        entry;
    logic [8:0]  entry_num;
    logic        entry_vec_b0;
    logic        ret;
    logic [31:0] ret_code;
    logic [8:0]  ret_num;
    logic [31:0] ret_psr;
    logic        interwork;
    logic        interwork_b0;
    logic        multi_int;
    logic [3:0]  multi_next;
    logic        multi_done;
    logic        cb_open;
    logic [7:0]  cb_state;
    logic        cb_step;
    logic        float_use;
  } cems_core_ev_s;
  typedef enum logic [1:0] {CEMS_IDLE, CEMS_SUSPENDED, CEMS_RESUMING} cems_multi_e;
  typedef struct packed {
    logic [8:0]  exc_num;
    logic [7:0]  cb_state;
    logic        state_bit;
    logic [3:0]  prog;
    cems_multi_e mst;
    logic        cfg_mask;
    logic        fault_mask;
    logic [7:0]  thresh;
    logic        stack_sel;
    logic        float_act;
    logic [31:0] rdata;
  } cems_state_s;
endpackage
